/* File: core/ecdma_defs.vh */
/*
 * Constants of the eight-channel DMA controller: register map, field layout
 * and reset values.
 * Assumes inclusion by bare name from the core files.
 */
`ifndef ECDMA_DEFS_VH
`define ECDMA_DEFS_VH

// Per-channel register block: channel n occupies byte offsets n*0x20 + reg*4.
`define ECDMA_CH_STRIDE_SH   5
`define ECDMA_REG_CONFIG     3'h0
`define ECDMA_REG_PBASE      3'h1
`define ECDMA_REG_MBASE      3'h2
`define ECDMA_REG_COUNT      3'h3
`define ECDMA_REG_FLAGS      3'h4
`define ECDMA_REG_SWTRIG     3'h5

// Field positions of channel_config.
`define ECDMA_CFG_EN         0
`define ECDMA_CFG_FDIE       1
`define ECDMA_CFG_HDIE       2
`define ECDMA_CFG_DIR        4
`define ECDMA_CFG_CIRCULAR_SELECT       5
`define ECDMA_CFG_PERIPHERAL_POINTER_INCREMENT       6
`define ECDMA_CFG_MEMORY_POINTER_INCREMENT       7
`define ECDMA_CFG_PSZ_LO     8
`define ECDMA_CFG_MSZ_LO     10
`define ECDMA_CFG_PL_LO      12
`define ECDMA_CFG_M2M        14
`define ECDMA_CFG_W          15

// Flags register bits; a write of one clears.
`define ECDMA_FLG_FULL       1
`define ECDMA_FLG_HALF       2

`define ECDMA_CFG_RESET      15'h0000
`define ECDMA_SIZE_BYTE      2'h0
`define ECDMA_SIZE_HALF      2'h1
`define ECDMA_SIZE_WORD      2'h2

// Bus states.
`define ECDMA_ST_IDLE        2'h0
`define ECDMA_ST_READ        2'h1
`define ECDMA_ST_WRITE       2'h2
`define ECDMA_ST_DONE        2'h3

`endif

/* File: core/ecdma_arbiter.v */
/*
 * Single-pass combinational channel arbiter: highest software level wins, ties go to the
 * lower channel index.
 * Assumes request and level vectors from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module ecdma_arbiter #(
  parameter NCH = 8
) (
  input  wire [NCH-1:0]   req,
  input  wire [2*NCH-1:0] level,
  output reg              any,
  output reg  [2:0]       sel
);

  integer i;
  reg [1:0] best;

  // Scan downward so the lowest index of the highest level stays selected.
  always @* begin
    any  = 1'b0;
    sel  = 3'h0;
    best = 2'h0;
    for (i = NCH-1; i >= 0; i = i - 1) begin
      if (req[i] && (!any || level[2*i +: 2] >= best)) begin
        any  = 1'b1;
        sel  = i[2:0];
        best = level[2*i +: 2];
      end
    end
  end

endmodule // ecdma_arbiter

`default_nettype wire

/* File: core/ecdma_top.v */
/*
 * Eight-channel DMA controller: channel registers, arbiter, bus master and
 * peripheral request/acknowledge handshake.
 * Assumes a system bus with a ready answer, read data valid with ready.
 */
// What this block does
// - Eight channels, each with its own request line plus a software trigger.
// - Per-channel priority of four levels in the channel configuration.
// - Equal priority ties go to the lower channel index.
// - Source and destination item sizes independent; pack or unpack data.
// - Circular mode repeats the same buffer without reprogramming, except on a memory-to-memory channel.
// - Half and full done flags ORed into one interrupt per channel.
// - Peripheral/memory directions in all combinations, memory-to-memory supported.
// - Item count programmable up to 65536.
// - Acts as bus master sharing the bus; may be stalled.
// - Bus matrix round-robin leaves processor at least half the bandwidth.
// - Serve in priority order; acknowledge when accessing the peripheral.
// - Hold acknowledge until request drops, then release it.
// - Load item from source via current address, initialised from base.
// - Store item to destination via current address, from base.
// - Decrement remaining count after each transfer.
// - Increment pointer by item size; base registers unchanged.
// - Non-circular channel serves nothing once count reaches zero.
// - Circular, not memory-to-memory: reload count and addresses after the last transfer.
// - Half flag at half, full flag at end; enables gate interrupts.
`timescale 1ns/100ps
`default_nettype none
`include "ecdma_defs.vh"

module ecdma_top #(
  parameter NCH = 8
) (
  input  wire              clock,
  input  wire              rst_n,
  // Register port.
  input  wire [7:0]        reg_addr,
  input  wire [31:0]       reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [31:0]       reg_rdata_q,
  // Peripheral handshake.
  input  wire [NCH-1:0]    dreq,
  output reg  [NCH-1:0]    dack_q,
  output reg  [NCH-1:0]    irq_q,
  // System bus master.
  output reg               bus_req_q,
  output reg               bus_write_q,
  output reg  [31:0]       bus_addr_q,
  output reg  [1:0]        bus_size_q,
  output reg  [31:0]       bus_wdata_q,
  input  wire              bus_ready,
  input  wire [31:0]       bus_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Byte step of one item of the given size.
  function [31:0] ecdma_step;
    input [1:0] sz;
    begin
      ecdma_step = (sz == `ECDMA_SIZE_BYTE) ? 32'h00000001 :
                   (sz == `ECDMA_SIZE_HALF) ? 32'h00000002 : 32'h00000004;
    end
  endfunction

  // Keep only the low lanes that the item size carries.
  function [31:0] ecdma_trim;
    input [31:0] d;
    input [1:0]  sz;
    begin
      ecdma_trim = (sz == `ECDMA_SIZE_BYTE) ? {24'h000000, d[7:0]} :
                   (sz == `ECDMA_SIZE_HALF) ? {16'h0000, d[15:0]} : d;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Channel state.

  reg [`ECDMA_CFG_W-1:0] cfg_q   [0:NCH-1];
  reg [31:0]             pbase_q [0:NCH-1];
  reg [31:0]             mbase_q [0:NCH-1];
  reg [16:0]             init_q  [0:NCH-1];
  reg [16:0]             cnt_q   [0:NCH-1];
  reg [31:0]             pcur_q  [0:NCH-1];
  reg [31:0]             mcur_q  [0:NCH-1];
  reg [NCH-1:0]          half_q;
  reg [NCH-1:0]          full_q;
  reg [NCH-1:0]          swreq_q;
  reg [NCH-1:0]          sync1_q;
  reg [NCH-1:0]          sync2_q;

  // Sequencer state and the channel that won the last round.
  reg [1:0]  st_q;
  reg [2:0]  ch_q;

  // Register port decode: channel in the top bits, register just below it.
  wire [2:0] rch = reg_addr[7:`ECDMA_CH_STRIDE_SH];
  wire [2:0] rrg = reg_addr[4:2];

  ////////////////////////////////////////////////////////////////////////////
  // Request gathering and arbitration.

  // Pending set and level vector handed to the arbiter.
  reg [NCH-1:0]   pend;
  reg [2*NCH-1:0] lvls;
  integer k;

  // A channel competes while enabled, holding items and not waiting on ack.
  always @* begin
    pend = {NCH{1'b0}};
    lvls = {2*NCH{1'b0}};
    for (k = 0; k < NCH; k = k + 1) begin
      lvls[2*k +: 2] = cfg_q[k][`ECDMA_CFG_PL_LO +: 2];
      if (cfg_q[k][`ECDMA_CFG_EN] && cnt_q[k] != 17'h00000 && !dack_q[k]) begin
        pend[k] = cfg_q[k][`ECDMA_CFG_M2M] || swreq_q[k] || sync2_q[k];
      end
    end
  end

  // Winner of the current round; only looked at while the sequencer idles.
  wire       arb_any;
  wire [2:0] arb_sel;

  ecdma_arbiter #(
    .NCH   (NCH)
  ) u_arb (
    .req   (pend),
    .level (lvls),
    .any   (arb_any),
    .sel   (arb_sel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transfer sequencer.

  // Fields of the granted channel; they steer the write phase and the post-update of the item.
  wire [`ECDMA_CFG_W-1:0] ccfg = cfg_q[ch_q];
  wire        dir_m2p = ccfg[`ECDMA_CFG_DIR];
  wire [1:0]  psz     = ccfg[`ECDMA_CFG_PSZ_LO +: 2];
  wire [1:0]  msz     = ccfg[`ECDMA_CFG_MSZ_LO +: 2];
  wire [1:0]  src_sz  = dir_m2p ? msz : psz;
  wire [1:0]  dst_sz  = dir_m2p ? psz : msz;
  wire [31:0] dst_a   = dir_m2p ? pcur_q[ch_q] : mcur_q[ch_q];
  wire [16:0] cnt_nx  = cnt_q[ch_q] - 17'h00001;
  wire        last    = (cnt_nx == 17'h00000);
  wire        halfway = (cnt_nx == {1'b0, init_q[ch_q][16:1]});

  // Loop index shared by the reset and the per-channel updates.
  integer j;

  // One item per grant, then back to idle so the arbiter looks again.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q        <= `ECDMA_ST_IDLE;
      ch_q        <= 3'h0;
      bus_req_q   <= 1'b0;
      bus_write_q <= 1'b0;
      bus_addr_q  <= 32'h00000000;
      bus_size_q  <= 2'h0;
      bus_wdata_q <= 32'h00000000;
      dack_q      <= {NCH{1'b0}};
      sync1_q     <= {NCH{1'b0}};
      sync2_q     <= {NCH{1'b0}};
      half_q      <= {NCH{1'b0}};
      full_q      <= {NCH{1'b0}};
      swreq_q     <= {NCH{1'b0}};
      irq_q       <= {NCH{1'b0}};
      reg_rdata_q <= 32'h00000000;
      // A channel starts disabled, with an empty count and zero addresses.
      for (j = 0; j < NCH; j = j + 1) begin
        cfg_q[j]   <= `ECDMA_CFG_RESET;
        pbase_q[j] <= 32'h00000000;
        mbase_q[j] <= 32'h00000000;
        init_q[j]  <= 17'h00000;
        cnt_q[j]   <= 17'h00000;
        pcur_q[j]  <= 32'h00000000;
        mcur_q[j]  <= 32'h00000000;
      end
    end else begin
      // Request lines come from unclocked logic, so two flops guard them.
      sync1_q <= dreq;
      sync2_q <= sync1_q;
      // Acknowledge drops only after the synchronised request has gone.
      for (j = 0; j < NCH; j = j + 1) begin
        if (dack_q[j] && !sync2_q[j]) begin
          dack_q[j] <= 1'b0;
        end
      end
      // Software writes; hardware flag sets are applied later and win.
      if (reg_wr) begin
        case (rrg)
          `ECDMA_REG_CONFIG: begin
            cfg_q[rch] <= reg_wdata[`ECDMA_CFG_W-1:0];
            if (reg_wdata[`ECDMA_CFG_EN] && !cfg_q[rch][`ECDMA_CFG_EN]) begin
              pcur_q[rch] <= pbase_q[rch];
              mcur_q[rch] <= mbase_q[rch];
            end
          end
          `ECDMA_REG_PBASE: pbase_q[rch] <= reg_wdata;
          `ECDMA_REG_MBASE: mbase_q[rch] <= reg_wdata;
          `ECDMA_REG_COUNT: begin
            // Count loads only while the channel is disabled; 0 means 65536.
            if (!cfg_q[rch][`ECDMA_CFG_EN]) begin
              init_q[rch] <= (reg_wdata[15:0] == 16'h0000) ? 17'h10000 :
                             {1'b0, reg_wdata[15:0]};
              cnt_q[rch]  <= (reg_wdata[15:0] == 16'h0000) ? 17'h10000 :
                             {1'b0, reg_wdata[15:0]};
            end
          end
          `ECDMA_REG_FLAGS: begin
            if (reg_wdata[`ECDMA_FLG_FULL]) full_q[rch] <= 1'b0;
            if (reg_wdata[`ECDMA_FLG_HALF]) half_q[rch] <= 1'b0;
          end
          `ECDMA_REG_SWTRIG: swreq_q[rch] <= reg_wdata[0];
          default: ;
        endcase
      end
      // Register reads.
      if (reg_rd) begin
        case (rrg)
          `ECDMA_REG_CONFIG: reg_rdata_q <= {17'h00000, cfg_q[rch]};
          `ECDMA_REG_PBASE:  reg_rdata_q <= pbase_q[rch];
          `ECDMA_REG_MBASE:  reg_rdata_q <= mbase_q[rch];
          `ECDMA_REG_COUNT:  reg_rdata_q <= {15'h0000, cnt_q[rch]};
          `ECDMA_REG_FLAGS:  reg_rdata_q <= {29'h00000000, half_q[rch], full_q[rch],
                                            (half_q[rch] | full_q[rch])};
          `ECDMA_REG_SWTRIG: reg_rdata_q <= {31'h00000000, swreq_q[rch]};
          default:           reg_rdata_q <= 32'h00000000;
        endcase
      end else begin
        reg_rdata_q <= 32'h00000000;
      end
      // Item sequencer: idle, read phase, write phase, then the post-update.
      case (st_q)
        `ECDMA_ST_IDLE: begin
          if (arb_any) begin
            ch_q        <= arb_sel;
            st_q        <= `ECDMA_ST_READ;
            bus_req_q   <= 1'b1;
            bus_write_q <= 1'b0;
            bus_addr_q  <= cfg_q[arb_sel][`ECDMA_CFG_DIR] ? mcur_q[arb_sel] : pcur_q[arb_sel];
            bus_size_q  <= cfg_q[arb_sel][`ECDMA_CFG_DIR] ?
                           cfg_q[arb_sel][`ECDMA_CFG_MSZ_LO +: 2] :
                           cfg_q[arb_sel][`ECDMA_CFG_PSZ_LO +: 2];
          end
        end
        `ECDMA_ST_READ: begin
          // The matrix may stall us for processor turns; wait on ready.
          if (bus_ready) begin
            // Cut to the source size, then to the destination size, zero extended.
            bus_write_q <= 1'b1;
            bus_addr_q  <= dst_a;
            bus_size_q  <= dst_sz;
            bus_wdata_q <= ecdma_trim(ecdma_trim(bus_rdata, src_sz), dst_sz);
            st_q        <= `ECDMA_ST_WRITE;
            if (!ccfg[`ECDMA_CFG_M2M] && !swreq_q[ch_q]) begin
              dack_q[ch_q] <= 1'b1;
            end
          end
        end
        `ECDMA_ST_WRITE: begin
          if (bus_ready) begin
            bus_req_q   <= 1'b0;
            bus_write_q <= 1'b0;
            st_q        <= `ECDMA_ST_DONE;
          end
        end
        `ECDMA_ST_DONE: begin
          // Post-update the channel; base registers stay as programmed.
          swreq_q[ch_q] <= 1'b0;
          if (ccfg[`ECDMA_CFG_PERIPHERAL_POINTER_INCREMENT]) pcur_q[ch_q] <= pcur_q[ch_q] + ecdma_step(psz);
          if (ccfg[`ECDMA_CFG_MEMORY_POINTER_INCREMENT]) mcur_q[ch_q] <= mcur_q[ch_q] + ecdma_step(msz);
          cnt_q[ch_q] <= cnt_nx;
          if (halfway) half_q[ch_q] <= 1'b1;
          if (last) begin
            full_q[ch_q] <= 1'b1;
            if (ccfg[`ECDMA_CFG_CIRCULAR_SELECT] && !ccfg[`ECDMA_CFG_M2M]) begin
              cnt_q[ch_q]  <= init_q[ch_q];
              pcur_q[ch_q] <= pbase_q[ch_q];
              mcur_q[ch_q] <= mbase_q[ch_q];
            end
          end
          st_q <= `ECDMA_ST_IDLE;
        end
        default: st_q <= `ECDMA_ST_IDLE;
      endcase
      // One interrupt line per channel, gated by the two enables.
      for (j = 0; j < NCH; j = j + 1) begin
        irq_q[j] <= (half_q[j] & cfg_q[j][`ECDMA_CFG_HDIE]) |
                    (full_q[j] & cfg_q[j][`ECDMA_CFG_FDIE]);
      end
    end
  end

endmodule // ecdma_top

`default_nettype wire

/* File: tb/ecdma_top_sva.sv */
/* Port checker for the eight-channel DMA controller.
   Assumes the bind below attaches it to every ecdma_top instance. */
`timescale 1ns/100ps
`default_nettype none
module ecdma_sva #(
  parameter NCH = 8
) (
  input wire logic           clock,
  input wire logic           rst_n,
  input wire logic [NCH-1:0] dreq,
  input wire logic [NCH-1:0] dack_q,
  input wire logic           bus_req_q,
  input wire logic           bus_write_q,
  input wire logic [31:0]    bus_addr_q,
  input wire logic [1:0]     bus_size_q,
  input wire logic [31:0]    bus_wdata_q,
  input wire logic           bus_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ack_hold: assert property (1'b1 |=> (dack_q & $past(dack_q & dreq)) == $past(dack_q & dreq))
    else $error("ack dropped while its request was high");
  a_ack_release: assert property ((dack_q & ~dreq) != 0 |-> ##[1:4] (dack_q & ~dreq) == 0)
    else $error("ack kept too long after request fell");
  a_ack_single: assert property ($onehot0(dack_q))
    else $error("more than one ack at once");
  a_ack_cause: assert property ((dack_q & ~$past(dack_q)) != 0 |-> $past(bus_req_q && !bus_write_q && bus_ready))
    else $error("ack rose without a completed read");
  a_read_write: assert property (bus_req_q && !bus_write_q && bus_ready |=> bus_req_q && bus_write_q)
    else $error("no write phase after read");
  a_item_gap: assert property (bus_req_q && bus_write_q && bus_ready |=> !bus_req_q)
    else $error("no idle cycle between items");
  a_stall_hold: assert property (bus_req_q && !bus_ready |=> bus_req_q && $stable(bus_addr_q) && $stable(bus_write_q))
    else $error("bus request changed while stalled");
  a_wdata_width: assert property (bus_req_q && bus_write_q |-> (bus_size_q != 2'h0 || bus_wdata_q[31:8] == 24'h0) && (bus_size_q != 2'h1 || bus_wdata_q[31:16] == 16'h0))
    else $error("write data wider than item size");
  a_size_legal: assert property (bus_req_q |-> bus_size_q != 2'h3)
    else $error("illegal item size on bus");
endmodule // ecdma_sva
////////////////////////////////////////////////////////////////////////////////
bind ecdma_top ecdma_sva #(.NCH(NCH)) sva_u (.clock, .rst_n, .dreq, .dack_q, .bus_req_q,
  .bus_write_q, .bus_addr_q, .bus_size_q, .bus_wdata_q, .bus_ready);
`default_nettype wire

/* File: tb/ecdma_bus_model.sv */
/* System bus slave standing in for memory and peripheral registers.
   Assumes one read phase then one write phase per item, each ended by ready. */
`timescale 1ns/100ps
`default_nettype none
module ecdma_bus_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        bus_req,
  input  wire logic        bus_write,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic [3:0]  wait_n,
  output var  logic        bus_ready,
  output wire logic [31:0] bus_rdata,
  output var  logic [7:0]  wr_cnt,
  output var  logic [31:0] wr_addr,
  output var  logic [31:0] wr_data
);
  logic [3:0]  stall_q;
  logic [31:0] word;
  // Content is a function of the address, so no storage is needed.
  assign word = bus_addr ^ 32'h5A5A5A5A;
  // Outside a read answer the lines show the inverse, so stale data never matches.
  assign bus_rdata = (bus_ready && !bus_write) ? word : ~word;
  // Each phase is stalled wait_n cycles, as when the processor holds the bus.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stall_q <= 4'h0;
      bus_ready <= 1'b0;
      wr_cnt <= 8'h00;
      wr_addr <= 32'h0;
      wr_data <= 32'h0;
    end else if (bus_ready || !bus_req) begin
      stall_q <= 4'h0;
      bus_ready <= 1'b0;
    end else if (stall_q == wait_n) begin
      bus_ready <= 1'b1;
      if (bus_write) begin
        wr_cnt <= wr_cnt + 8'h01;
        wr_addr <= bus_addr;
        wr_data <= bus_wdata;
      end
    end else begin
      stall_q <= stall_q + 4'h1;
    end
  end
endmodule // ecdma_bus_model
`default_nettype wire

/* File: tb/ecdma_top_tb_top.sv */
/* Self-checking bench for the DMA controller: registers, handshake, priority.
   Assumes the bus model and the bound checker are compiled alongside. */
`timescale 1ns/100ps
`default_nettype none
module ecdma_top_tb_top;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [7:0]  dreq = 8'h00;
  logic [3:0]  wait_n = 4'h0;
  logic [7:0]  dack_q, irq_q, wr_cnt;
  logic        bus_req_q, bus_write_q, bus_ready;
  logic [1:0]  bus_size_q;
  logic [31:0] reg_rdata_q, bus_addr_q, bus_wdata_q, bus_rdata, wr_addr, wr_data;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  ecdma_top #(.NCH(8)) dut_u (.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata_q, .dreq, .dack_q, .irq_q, .bus_req_q, .bus_write_q, .bus_addr_q,
    .bus_size_q, .bus_wdata_q, .bus_ready, .bus_rdata);
  ecdma_bus_model mem_u (.clock, .rst_n, .bus_req(bus_req_q), .bus_write(bus_write_q),
    .bus_addr(bus_addr_q), .bus_wdata(bus_wdata_q), .wait_n, .bus_ready, .bus_rdata,
    .wr_cnt, .wr_addr, .wr_data);
  // A 5 ns clock.
  always #2.5 clock = ~clock;
  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("n_errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] ch, input logic [2:0] r, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= {ch, r, 2'b00};
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken there.
  task automatic rdc(input logic [2:0] ch, input logic [2:0] r, input logic [31:0] exp);
    @(posedge clock);
    reg_addr <= {ch, r, 2'b00};
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q, exp);
  endtask
  function automatic logic [31:0] cfg(input logic [1:0] pl, ms, ps, input logic [7:0] lo);
    return {18'h0, pl, ms, ps, lo};
  endfunction
  task automatic setup(input logic [2:0] ch, input logic [31:0] pb, mb, n, c);
    wr(ch, 3'h1, pb);
    wr(ch, 3'h2, mb);
    wr(ch, 3'h3, n);
    wr(ch, 3'h0, c);
  endtask
  task automatic ackw(input int ch, input logic v);
    for (int i = 0; i < 200 && dack_q[ch] !== v; i++) @(posedge clock);
    chk(dack_q[ch], v);
  endtask
  // Peripheral side of one item; the next request waits for bus idle.
  task automatic item(input int ch);
    @(posedge clock);
    dreq[ch] <= 1'b1;
    ackw(ch, 1'b1);
    dreq[ch] <= 1'b0;
    ackw(ch, 1'b0);
    for (int i = 0; i < 200 && bus_req_q !== 1'b0; i++) @(posedge clock);
    repeat (3) @(posedge clock);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk(dack_q, 8'h00);
    chk(irq_q, 8'h00);
    rdc(3'h0, 3'h0, 32'h0);
    wr(3'h7, 3'h3, 32'h0);
    rdc(3'h7, 3'h3, 32'h10000);
    wr(3'h0, 3'h6, 32'hFFFFFFFF);
    rdc(3'h0, 3'h6, 32'h0);
  endtask
  task automatic t_basic();
    setup(3'h1, 32'h40, 32'h1000, 32'h2, cfg(2'h0, 2'h2, 2'h2, 8'h87));
    item(1);
    chk(wr_addr, 32'h1000);
    chk(wr_data, 32'h5A5A5A1A);
    rdc(3'h1, 3'h3, 32'h1);
    rdc(3'h1, 3'h4, 32'h5);
    chk(irq_q[1], 1'b1);
    wr(3'h1, 3'h4, 32'h7);
    item(1);
    chk(wr_addr, 32'h1004);
    chk(wr_data, 32'h5A5A5A1A);
    rdc(3'h1, 3'h3, 32'h0);
    rdc(3'h1, 3'h4, 32'h3);
    @(posedge clock);
    dreq[1] <= 1'b1;
    repeat (30) @(posedge clock);
    chk(dack_q[1], 1'b0);
    chk(wr_cnt, 8'h02);
    dreq[1] <= 1'b0;
  endtask
  // Four channels ask at once: the top level first, then ties by lower index.
  task automatic t_prio();
    int order[4] = '{5, 2, 4, 6};
    setup(3'h2, 32'h200, 32'h1200, 32'h1, cfg(2'h1, 2'h2, 2'h2, 8'h01));
    setup(3'h4, 32'h400, 32'h1400, 32'h1, cfg(2'h1, 2'h2, 2'h2, 8'h01));
    setup(3'h5, 32'h500, 32'h1500, 32'h1, cfg(2'h3, 2'h2, 2'h2, 8'h01));
    setup(3'h6, 32'h600, 32'h1600, 32'h1, cfg(2'h0, 2'h2, 2'h2, 8'h01));
    @(posedge clock);
    dreq <= 8'h74;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 200 && dack_q === 8'h00; i++) @(posedge clock);
      chk(dack_q, 8'h01 << order[k]);
      dreq[order[k]] <= 1'b0;
      ackw(order[k], 1'b0);
    end
  endtask
  task automatic t_circular_select();
    setup(3'h3, 32'h80, 32'h3000, 32'h1, cfg(2'h0, 2'h2, 2'h2, 8'hA1));
    item(3);
    chk(wr_addr, 32'h3000);
    rdc(3'h3, 3'h3, 32'h1);
    chk(irq_q[3], 1'b0);
    item(3);
    chk(wr_addr, 32'h3000);
  endtask
  // Byte source into a half-word destination under a stalling bus.
  task automatic t_pack();
    wait_n <= 4'h3;
    setup(3'h0, 32'h500, 32'h2001, 32'h1, cfg(2'h0, 2'h0, 2'h1, 8'h11));
    item(0);
    chk(wr_addr, 32'h500);
    chk(wr_data, 32'h5B);
  endtask
  // Memory-to-memory runs by itself; a software trigger moves one item; neither acks.
  task automatic t_soft();
    logic [7:0] seen;
    logic [7:0] base;
    seen = 8'h00;
    base = wr_cnt;
    setup(3'h7, 32'h700, 32'h4000, 32'h2, cfg(2'h2, 2'h2, 2'h2, 8'hC1) | 32'h4000);
    repeat (60) begin
      @(posedge clock);
      seen = seen | dack_q;
    end
    chk(wr_cnt, base + 8'h02);
    chk(wr_addr, 32'h4004);
    chk(wr_data, 32'h5A5A5D5E);
    chk(seen, 8'h00);
    rdc(3'h7, 3'h3, 32'h0);
    rdc(3'h7, 3'h4, 32'h7);
    wr(3'h7, 3'h0, 32'h0);
    setup(3'h7, 32'h7F0, 32'h5000, 32'h1, cfg(2'h0, 2'h2, 2'h2, 8'h01));
    repeat (20) @(posedge clock);
    chk(wr_cnt, base + 8'h02);
    wr(3'h7, 3'h5, 32'h1);
    repeat (40) begin
      @(posedge clock);
      seen = seen | dack_q;
    end
    chk(wr_cnt, base + 8'h03);
    chk(wr_addr, 32'h5000);
    chk(wr_data, 32'h5A5A5DAA);
    chk(seen, 8'h00);
    rdc(3'h7, 3'h5, 32'h0);
  endtask
  // Main sequence.
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_basic();
    t_prio();
    t_circular_select();
    t_pack();
    t_soft();
    stop_test();
  end
endmodule // ecdma_top_tb_top
`default_nettype wire
